// ### src/lcf_top.sv
// Lock current fault response with Avalon-MM register slave
`timescale 1ns/100ps
module lcf_top #(
    parameter int US_SCALE  = 125,
    parameter int US_PER_MS = 1000,
    parameter int ADC_W     = 12
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic [ADC_W-1:0] phase_current,
    input  wire logic [ADC_W-1:0] full_scale_current,
    input  wire logic             sample_valid,
    output logic [2:0]            gate_hs,
    output logic [2:0]            gate_ls,
    output logic                  gate_tristate,
    output logic                  fault_out_n,
    output logic                  irq
);
    localparam int DW = 28;
    localparam int TW = 34;

    logic [31:0] cfg_reg, cfg_next;
    logic [lcf_pkg::ST_W-1:0] sts_reg, sts_next, msk_reg, msk_next;
    logic [3:0]  lim_reg, lim_next;
    logic        ack_reg, ack_next;
    logic [31:0] rd_reg, rd_next;
    logic        over_reg, over_next;
    lcf_pkg::lcf_state_t st_reg, st_next;
    logic [3:0]  rcnt_reg, rcnt_next;
    logic        brk_reg, brk_next;
    logic        tri_reg, tri_next;
    logic        flt_reg, flt_next;

    logic [3:0]  mode, deg, rsel, thr;
    logic        ev, rdone, sw_clr;
    logic [DW-1:0] deg_cyc;
    logic [TW-1:0] retry_cyc;
    logic [lcf_pkg::US_W-1:0] deg_us;
    logic [lcf_pkg::MS_W-1:0] retry_ms;
    logic [6:0]  pct;
    logic [ADC_W+6:0] lhs, rhs;
    logic        mode_dis, mode_brk, mode_retry, mode_rep;
    logic        sel_ok;

    assign mode = cfg_reg[lcf_pkg::MODE_HI:lcf_pkg::MODE_LO];
    assign deg  = cfg_reg[lcf_pkg::DEG_HI:lcf_pkg::DEG_LO];
    assign rsel = cfg_reg[lcf_pkg::RETRY_HI:lcf_pkg::RETRY_LO];
    assign thr  = cfg_reg[lcf_pkg::THR_HI:lcf_pkg::THR_LO];

    // ------------------------------------------------------------
    // Code tables
    // ------------------------------------------------------------
    always_comb begin
        unique case (deg)
            4'h0: deg_us = 24'h000000;
            4'h1: deg_us = 24'h000064;
            4'h2: deg_us = 24'h0000C8;
            4'h3: deg_us = 24'h0001F4;
            4'h4: deg_us = 24'h0003E8;
            4'h5: deg_us = 24'h0009C4;
            4'h6: deg_us = 24'h001388;
            4'h7: deg_us = 24'h001D4C;
            4'h8: deg_us = 24'h002710;
            4'h9: deg_us = 24'h0061A8;
            4'hA: deg_us = 24'h00C350;
            4'hB: deg_us = 24'h0124F8;
            4'hC: deg_us = 24'h0186A0;
            4'hD: deg_us = 24'h030D40;
            4'hE: deg_us = 24'h07A120;
            4'hF: deg_us = 24'h0F4240;
        endcase
    end

    always_comb begin
        unique case (rsel)
            4'h0:    retry_ms = 14'h012C;
            4'h1:    retry_ms = 14'h01F4;
            4'h2:    retry_ms = 14'h03E8;
            4'hF:    retry_ms = 14'h32C8;
            default: retry_ms = 14'((rsel - 4'h1) * 14'h03E8);
        endcase
    end

    always_comb begin
        unique case (thr)
            4'h0: pct = 7'h05;
            4'h1: pct = 7'h0A;
            4'h2: pct = 7'h0F;
            4'h3: pct = 7'h14;
            4'h4: pct = 7'h19;
            4'h5: pct = 7'h1E;
            4'h6: pct = 7'h28;
            4'h7: pct = 7'h32;
            4'h8: pct = 7'h3C;
            4'h9: pct = 7'h41;
            4'hA: pct = 7'h46;
            4'hB: pct = 7'h4B;
            4'hC: pct = 7'h50;
            4'hD: pct = 7'h55;
            4'hE: pct = 7'h5A;
            4'hF: pct = 7'h5F;
        endcase
    end

    assign deg_cyc   = DW'(deg_us * 32'(US_SCALE));
    assign retry_cyc = TW'(64'(retry_ms) * 64'(US_SCALE) * 64'(US_PER_MS));
    assign lhs = (ADC_W+7)'(phase_current) * (ADC_W+7)'(7'h64);
    assign rhs = (ADC_W+7)'(full_scale_current) * (ADC_W+7)'(pct);

    always_comb begin
        mode_dis   = 1'b0;
        mode_brk   = 1'b0;
        mode_retry = 1'b0;
        mode_rep   = 1'b0;
        unique case (mode)
            4'h0, 4'h1: mode_brk = 1'b0;
            4'h2, 4'h3: mode_brk = 1'b1;
            4'h4, 4'h5: mode_retry = 1'b1;
            4'h6, 4'h7: begin
                mode_retry = 1'b1;
                mode_brk   = 1'b1;
            end
            lcf_pkg::MODE_REPORT: mode_rep = 1'b1;
            default: mode_dis = 1'b1;
        endcase
    end
    assign sel_ok = !mode_dis;

    // ------------------------------------------------------------
    // Threshold compare and filter
    // ------------------------------------------------------------
    always_comb begin
        over_next = over_reg;
        if (sample_valid) begin
            over_next = lhs > rhs;
        end
    end

    lcf_deglitch #(.CNT_W(DW)) u_deg (
        .mclk    (mclk),
        .rst     (rst),
        .cond    (over_reg && sel_ok && st_reg == lcf_pkg::LCF_IDLE),
        .need    (deg_cyc),
        .event_p (ev)
    );

    lcf_timer #(.CNT_W(TW)) u_tmr (
        .mclk (mclk),
        .rst  (rst),
        .run  (st_reg == lcf_pkg::LCF_ACTIVE && mode_retry),
        .need (retry_cyc),
        .done (rdone)
    );

    // ------------------------------------------------------------
    // Fault state machine
    // ------------------------------------------------------------
    always_comb begin
        st_next   = st_reg;
        rcnt_next = rcnt_reg;
        brk_next  = 1'b0;
        tri_next  = 1'b0;
        flt_next  = 1'b0;
        unique case (st_reg)
            lcf_pkg::LCF_IDLE: begin
                if (ev && !mode_rep) begin
                    st_next = mode_retry ? lcf_pkg::LCF_ACTIVE : lcf_pkg::LCF_LATCHED;
                end
            end
            lcf_pkg::LCF_ACTIVE: begin
                if (!mode_retry || !sel_ok) begin
                    st_next = lcf_pkg::LCF_IDLE;
                end else if (rdone) begin
                    if (rcnt_reg >= lim_reg) begin
                        st_next = lcf_pkg::LCF_LATCHED;
                    end else begin
                        rcnt_next = rcnt_reg + 4'h1;
                        st_next   = lcf_pkg::LCF_IDLE;
                    end
                end
            end
            lcf_pkg::LCF_LATCHED: begin
                if (sw_clr) begin
                    st_next   = lcf_pkg::LCF_IDLE;
                    rcnt_next = 4'h0;
                end
            end
        endcase
        if (st_next != lcf_pkg::LCF_IDLE) begin
            flt_next = 1'b1;
            brk_next = mode_brk;
            tri_next = !mode_brk;
        end else if (mode_rep && over_reg) begin
            flt_next = ev || flt_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg   <= lcf_pkg::LCF_IDLE;
            rcnt_reg <= 4'h0;
            brk_reg  <= 1'b0;
            tri_reg  <= 1'b0;
            flt_reg  <= 1'b0;
            over_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            rcnt_reg <= rcnt_next;
            brk_reg  <= brk_next;
            tri_reg  <= tri_next;
            flt_reg  <= flt_next;
            over_reg <= over_next;
        end
    end

    assign gate_hs       = 3'h0;
    assign gate_ls       = {3{brk_reg}};
    assign gate_tristate = tri_reg;
    assign fault_out_n   = !flt_reg;

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    assign sw_clr = avs_write && !ack_reg && avs_address == lcf_pkg::ADDR_CTRL
                    && avs_byteenable[0] && avs_writedata[lcf_pkg::CTRL_CLR];

    always_comb begin
        cfg_next = cfg_reg;
        msk_next = msk_reg;
        lim_next = lim_reg;
        rd_next  = rd_reg;
        ack_next = (avs_read || avs_write) && !ack_reg;
        sts_next = sts_reg;
        if (avs_read && !ack_reg) begin
            unique case (avs_address)
                lcf_pkg::ADDR_CONFIG: rd_next = cfg_reg;
                lcf_pkg::ADDR_STATUS: begin
                    rd_next  = 32'(sts_reg);
                    sts_next = '0;
                end
                lcf_pkg::ADDR_MASK:   rd_next = 32'(msk_reg);
                lcf_pkg::ADDR_CTRL:   rd_next = {20'h00000, lim_reg, 8'h00};
                default:              rd_next = 32'h0000_0000;
            endcase
        end
        if (avs_write && !ack_reg) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable[b] && avs_address == lcf_pkg::ADDR_CONFIG) begin
                    cfg_next[b*8 +: 8] = avs_writedata[b*8 +: 8]
                                         & lcf_pkg::CONFIG_WMSK[b*8 +: 8];
                end
            end
            if (avs_address == lcf_pkg::ADDR_MASK && avs_byteenable[0]) begin
                msk_next = avs_writedata[lcf_pkg::ST_W-1:0];
            end
            if (avs_address == lcf_pkg::ADDR_CTRL && avs_byteenable[1]) begin
                lim_next = avs_writedata[lcf_pkg::CTRL_LIM_HI:lcf_pkg::CTRL_LIM_LO];
            end
        end
        if (ev) begin
            sts_next[lcf_pkg::ST_EVENT] = 1'b1;
        end
        if (st_next == lcf_pkg::LCF_LATCHED && st_reg != lcf_pkg::LCF_LATCHED) begin
            sts_next[lcf_pkg::ST_LATCH] = 1'b1;
        end
        if (st_reg == lcf_pkg::LCF_ACTIVE && st_next == lcf_pkg::LCF_IDLE) begin
            sts_next[lcf_pkg::ST_CLEAR] = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_reg <= lcf_pkg::CONFIG_RST;
            msk_reg <= '0;
            lim_reg <= 4'h0;
            sts_reg <= '0;
            ack_reg <= 1'b0;
            rd_reg  <= 32'h0000_0000;
        end else begin
            cfg_reg <= cfg_next;
            msk_reg <= msk_next;
            lim_reg <= lim_next;
            sts_reg <= sts_next;
            ack_reg <= ack_next;
            rd_reg  <= rd_next;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign avs_readdata    = rd_reg;
    assign irq             = |(sts_reg & msk_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_mode;
        @(posedge mclk) $fell(rst) |-> mode == 4'h0;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not zero");

    property p_tristate;
        @(posedge mclk) disable iff (rst)
            (ev && !mode_brk && !mode_rep && !mode_dis) |=> gate_tristate && !fault_out_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("no tristate");

    property p_brake;
        @(posedge mclk) disable iff (rst)
            (ev && mode_brk && !mode_rep) |=> gate_ls == 3'h7 && !fault_out_n;
    endproperty
    a_brake: assert property (p_brake) else $error("no brake");

    property p_hs_off;
        @(posedge mclk) disable iff (rst) gate_ls != 3'h0 |-> gate_hs == 3'h0 && !gate_tristate;
    endproperty
    a_hs_off: assert property (p_hs_off) else $error("bad brake drive");

    property p_latch_hold;
        @(posedge mclk) disable iff (rst)
            (st_reg == lcf_pkg::LCF_LATCHED && !sw_clr) |=> st_reg == lcf_pkg::LCF_LATCHED;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

    property p_retry_limit;
        @(posedge mclk) disable iff (rst)
            (st_reg == lcf_pkg::LCF_ACTIVE && rdone && rcnt_reg >= lim_reg && mode_retry && sel_ok)
            |=> st_reg == lcf_pkg::LCF_LATCHED;
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("limit ignored");

    property p_report;
        @(posedge mclk) disable iff (rst) mode_rep && st_reg == lcf_pkg::LCF_IDLE
            |=> gate_ls == 3'h0 && !gate_tristate;
    endproperty
    a_report: assert property (p_report) else $error("report acted");

    property p_disabled;
        @(posedge mclk) disable iff (rst) mode_dis |=> !ev;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled raised event");
endmodule : lcf_top

// ### include/lcf_pkg.sv
// Constants for the lock current fault response block
package lcf_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CONFIG = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h1;
    localparam logic [3:0]  ADDR_MASK   = 4'h2;
    localparam logic [3:0]  ADDR_CTRL   = 4'h3;
    localparam logic [31:0] CONFIG_RST  = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMSK = 32'h7FFF_FFFF;
    localparam int MODE_HI  = 18;
    localparam int MODE_LO  = 15;
    localparam int DEG_HI   = 14;
    localparam int DEG_LO   = 11;
    localparam int RETRY_HI = 10;
    localparam int RETRY_LO = 7;
    localparam int THR_HI   = 22;
    localparam int THR_LO   = 19;
    localparam int CTRL_CLR  = 0;
    localparam int CTRL_LIM_LO = 8;
    localparam int CTRL_LIM_HI = 11;
    localparam int ST_EVENT = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_CLEAR = 2;
    localparam int ST_W     = 3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 125000;
    localparam int US_W    = 24;
    localparam int MS_W    = 14;
    localparam int CYC_PER_US = CLK_KHZ / 1000;
    // Response codes
    localparam logic [3:0] MODE_REPORT = 4'h8;
    typedef enum logic [1:0] {LCF_IDLE, LCF_ACTIVE, LCF_LATCHED} lcf_state_t;
endpackage : lcf_pkg

// ### src/lcf_deglitch.sv
// Persistence filter for the over-threshold condition
`timescale 1ns/100ps
module lcf_deglitch #(
    parameter int CNT_W = 28
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             cond,
    input  wire logic [CNT_W-1:0] need,
    output logic                  event_p
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             ev_reg;
    logic             ev_next;

    // ------------------------------------------------------------
    // Counter, restarts on any drop
    // ------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        ev_next  = 1'b0;
        if (!cond) begin
            cnt_next = '0;
        end else if (cnt_reg >= need) begin
            ev_next  = 1'b1;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            ev_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ev_reg  <= ev_next;
        end
    end

    assign event_p = ev_reg;

    property p_drop_clears;
        @(posedge mclk) disable iff (rst) !cond |=> cnt_reg == '0;
    endproperty
    a_drop_clears: assert property (p_drop_clears) else $error("filter not restarted");
endmodule : lcf_deglitch

// ### src/lcf_timer.sv
// Retry interval timer
`timescale 1ns/100ps
module lcf_timer #(
    parameter int CNT_W = 34
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] need,
    output logic                  done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // ------------------------------------------------------------
    // Count while running
    // ------------------------------------------------------------
    always_comb begin
        cnt_next = '0;
        if (run && cnt_reg < need) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done = run && (cnt_reg >= need);
endmodule : lcf_timer

// ### tb/lcf_gate_stage.sv
// Gate stage and current converter model on the far side of the block
`timescale 1ns/100ps
module lcf_gate_stage #(
    parameter int ADC_W = 12
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [2:0]       gate_hs,
    input  wire logic [2:0]       gate_ls,
    input  wire logic [ADC_W-1:0] level,
    output logic [ADC_W-1:0]      phase_current,
    output logic                  sample_valid,
    output logic                  shoot_through
);
    logic [1:0] div_reg;
    logic [1:0] div_next;
    // ------------------------------------------------------------
    // Converter sample strobe
    // ------------------------------------------------------------
    always_comb begin
        div_next = div_reg + 2'h1;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_next;
        end
    end
    assign sample_valid  = (div_reg == 2'h3);
    // Bus holds no valid value between samples
    assign phase_current = sample_valid ? level : ~level;
    // Both switches of one leg on would short the supply
    assign shoot_through = |(gate_hs & gate_ls);
endmodule : lcf_gate_stage

// ### tb/lcf_top_bench.sv
// Self-checking bench for the lock current fault response block
`timescale 1ns/100ps
module lcf_top_bench;
    typedef struct packed {
        logic [3:0] mode;
        logic       fa;
        logic       ts;
        logic [2:0] ls;
    } lcf_row_t;
    localparam logic [11:0] OVER = 12'h3E8;
    logic        mclk;
    logic        rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] lvl;
    logic [11:0] pc;
    logic [11:0] fsc;
    logic        sv;
    logic [2:0]  hs;
    logic [2:0]  ls;
    logic        ts;
    logic        fn;
    logic        irq;
    logic        sht;
    int          fail_count;
    int          tests_run;
    // Mode code, fault active, tristate, low-side gates
    lcf_row_t rows [16] = '{
        '{4'h0, 1'b1, 1'b1, 3'h0}, '{4'h1, 1'b1, 1'b1, 3'h0},
        '{4'h2, 1'b1, 1'b0, 3'h7}, '{4'h3, 1'b1, 1'b0, 3'h7},
        '{4'h4, 1'b1, 1'b1, 3'h0}, '{4'h5, 1'b1, 1'b1, 3'h0},
        '{4'h6, 1'b1, 1'b0, 3'h7}, '{4'h7, 1'b1, 1'b0, 3'h7},
        '{4'h8, 1'b1, 1'b0, 3'h0}, '{4'h9, 1'b0, 1'b0, 3'h0},
        '{4'hA, 1'b0, 1'b0, 3'h0}, '{4'hB, 1'b0, 1'b0, 3'h0},
        '{4'hC, 1'b0, 1'b0, 3'h0}, '{4'hD, 1'b0, 1'b0, 3'h0},
        '{4'hE, 1'b0, 1'b0, 3'h0}, '{4'hF, 1'b0, 1'b0, 3'h0}
    };
    lcf_top #(
        .US_SCALE  (1),
        .US_PER_MS (1),
        .ADC_W     (12)
    ) i_dut (
        .mclk               (mclk),
        .rst                (rst),
        .avs_address        (avs_address),
        .avs_read           (avs_read),
        .avs_write          (avs_write),
        .avs_writedata      (avs_writedata),
        .avs_byteenable     (avs_byteenable),
        .avs_readdata       (avs_readdata),
        .avs_waitrequest    (avs_waitrequest),
        .phase_current      (pc),
        .full_scale_current (fsc),
        .sample_valid       (sv),
        .gate_hs            (hs),
        .gate_ls            (ls),
        .gate_tristate      (ts),
        .fault_out_n        (fn),
        .irq                (irq)
    );
    lcf_gate_stage #(
        .ADC_W (12)
    ) i_stage (
        .mclk          (mclk),
        .rst           (rst),
        .gate_hs       (hs),
        .gate_ls       (ls),
        .level         (lvl),
        .phase_current (pc),
        .sample_valid  (sv),
        .shoot_through (sht)
    );
    // ------------------------------------------------------------
    // Clock and tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) begin
            chk(32'h1, 32'h0);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task wait_fault(input int lim);
        int n;
        n = 0;
        while (fn !== 1'b0 && n < lim) begin
            @(posedge mclk);
            n++;
        end
    endtask : wait_fault
    task do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
    endtask : do_reset
    function automatic logic [31:0] cfg(input logic [3:0] m, input logic [3:0] d);
        cfg = (32'(m) << lcf_pkg::MODE_LO) | (32'(d) << lcf_pkg::DEG_LO);
    endfunction : cfg
    initial begin
        #(8 * 40000);
        fail_count++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [8:0]  row_exp;
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        lvl = 12'h000;
        fsc = 12'h3E8;
        fail_count = 0;
        tests_run = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        bus(1'b0, lcf_pkg::ADDR_CONFIG, 32'h0, q);
        chk(q, lcf_pkg::CONFIG_RST);
        bus(1'b1, lcf_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, q);
        bus(1'b0, lcf_pkg::ADDR_CONFIG, 32'h0, q);
        chk(q, lcf_pkg::CONFIG_WMSK);
        bus(1'b0, 4'hF, 32'h0, q);
        chk(q, 32'h0);
        for (int i = 0; i < 16; i++) begin
            do_reset();
            bus(1'b1, lcf_pkg::ADDR_CONFIG, cfg(rows[i].mode, 4'h0), q);
            lvl <= OVER;
            wait_fault(40);
            repeat (4) @(posedge mclk);
            row_exp = {1'b0, 3'h0, rows[i].ls, rows[i].ts, ~rows[i].fa};
            chk({sht, hs, ls, ts, fn}, row_exp);
            lvl <= 12'h000;
        end
        // Report only: pin follows the condition, nothing latched
        bus(1'b1, lcf_pkg::ADDR_CONFIG, cfg(lcf_pkg::MODE_REPORT, 4'h0), q);
        lvl <= OVER;
        wait_fault(40);
        chk(fn, 1'b0);
        lvl <= 12'h000;
        repeat (20) @(posedge mclk);
        chk({28'h0, ts, fn}, 32'h1);
        // Filter of 100 cycles restarted by a short drop
        do_reset();
        bus(1'b1, lcf_pkg::ADDR_CONFIG, cfg(4'h0, 4'h1), q);
        lvl <= OVER;
        repeat (60) @(posedge mclk);
        lvl <= 12'h000;
        repeat (8) @(posedge mclk);
        lvl <= OVER;
        repeat (90) @(posedge mclk);
        chk(fn, 1'b1);
        wait_fault(120);
        chk(fn, 1'b0);
        lvl <= 12'h000;
        repeat (20) @(posedge mclk);
        chk({fn, irq}, 2'b00);
        bus(1'b1, lcf_pkg::ADDR_MASK, 32'h7, q);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        bus(1'b0, lcf_pkg::ADDR_STATUS, 32'h0, q);
        chk(q[2:0], 3'h3);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        bus(1'b0, lcf_pkg::ADDR_STATUS, 32'h0, q);
        chk(q, 32'h0);
        // External clear releases the latched fault
        bus(1'b1, lcf_pkg::ADDR_CTRL, 32'h1, q);
        repeat (4) @(posedge mclk);
        chk({ts, fn}, 2'b01);
        // Auto-retry with limit 1: one auto-clear, then latched
        do_reset();
        bus(1'b1, lcf_pkg::ADDR_CTRL, 32'h0000_0100, q);
        bus(1'b1, lcf_pkg::ADDR_CONFIG, cfg(4'h4, 4'h0), q);
        lvl <= OVER;
        wait_fault(40);
        chk(fn, 1'b0);
        repeat (400) @(posedge mclk);
        bus(1'b0, lcf_pkg::ADDR_STATUS, 32'h0, q);
        chk(q[2:0], 3'h5);
        repeat (400) @(posedge mclk);
        bus(1'b0, lcf_pkg::ADDR_STATUS, 32'h0, q);
        chk(q[2:0], 3'h2);
        chk({ts, fn}, 2'b10);
        lvl <= 12'h000;
        report_and_stop();
    end
endmodule : lcf_top_bench
